//--- design/pbsp_array.sv
// storage array with per-lane write and registered read port
`timescale 1ns/1ns
module pbsp_array
	import pbsp_pkg::*;
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [LANES-1:0] wr_lanes,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data_q
);
	////////////////////////////////////////////////////////////////////////
	// one storage column per byte lane, so no array has two writers
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic [LANE_W-1:0] lane_mem [DEPTH];

		always_ff @(posedge clk) begin
			if (wr_en && wr_lanes[g]) begin
				lane_mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
			end
		end

		// read data leaves through a register, held while not enabled
		always_ff @(posedge clk) begin
			if (rd_en) begin
				rd_data_q[g*LANE_W +: LANE_W] <= lane_mem[rd_addr];
			end
		end
	end
endmodule : pbsp_array

//--- design/pbsp_pkg.sv
// shared constants and types for the pipelined burst memory port
package pbsp_pkg;
	localparam int ADDR_W = 18;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int BURST_W = 2;
	localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
	localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h0;
	localparam logic [LANES-1:0] LANES_NONE = 4'h0;

	// operation carried down the pipeline
	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_READ = 2'b01,
		OP_WRITE = 2'b10
	} pbsp_op_e;

	// one pipeline stage: operation and full word address
	typedef struct packed {
		pbsp_op_e op;
		logic [ADDR_W-1:0] addr;
	} pbsp_stage_s;

	// record of the most recent array write, for forwarding
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lanes;
		logic [DATA_W-1:0] data;
	} pbsp_wrec_s;

	localparam pbsp_stage_s STAGE_IDLE = '{op: OP_IDLE, addr: ADDR_ZERO};
	localparam pbsp_wrec_s WREC_NONE = '{valid: 1'b0, addr: ADDR_ZERO, lanes: LANES_NONE, data: DATA_ZERO};
endpackage : pbsp_pkg

//--- design/pbsp_port.sv
// synchronous pipelined burst memory port, device side
// Operation
// - with burst order low the low two address bits step linearly, start plus count modulo four.
// - after the fourth beat the counter wraps to the loaded start and repeats while advances continue.
// - address, control and write data are taken only at the rising edge and read data is launched from it.
// - a selected read load in cycle n puts that word on the data bus during cycle n+2.
// - advance high continues a burst ignoring address and selects, stepping the counter once per enabled, unstalled cycle.
// - each advance gives the next beat two cycles later, so load plus three advances gives four beats in a row.
// - a load in the cycle of the fourth beat starts the next operation with no gap after the pipeline delay.
// - loads, bursts, deselects and idles mix freely on any cycle and the bus floats two cycles after a stop.
// - the device is selected only when both low-active selects are low and the high-active select is high.
// - read or write is ignored on advance cycles; the burst keeps the direction taken at its load.
// - clock enable high blocks the edge, so outside reset the pipeline registers, dq_out and dq_oe hold; the beat buffer still drains on beat_ready.
// - with burst order high the low two address bits are the start value xor the beat count.
`timescale 1ns/1ns
module pbsp_port
	import pbsp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [pbsp_pkg::ADDR_W-1:0] address,
	input wire logic read_write,
	input wire logic advance_or_load,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b,
	input wire logic chip_select_c_n,
	input wire logic clock_enable_n,
	input wire logic [pbsp_pkg::LANES-1:0] byte_write_strobes_n,
	input wire logic output_enable_n,
	input wire logic burst_order_select,
	input wire logic [pbsp_pkg::DATA_W-1:0] dq_in,
	output logic [pbsp_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic beat_valid,
	output logic [pbsp_pkg::DATA_W-1:0] beat_data,
	input wire logic beat_ready
);
	import pbsp_pkg::*;

	pbsp_stage_s s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
	pbsp_op_e burst_op_q, burst_op_d;
	logic [ADDR_W-1:0] base_q, base_d;
	logic [BURST_W-1:0] cnt_q, cnt_d;
	pbsp_wrec_s wrec_q, wrec_d;
	logic [DATA_W-1:0] dq_out_q, dq_out_d;
	logic dq_oe_q, dq_oe_d;
	logic [DATA_W-1:0] e0_q, e0_d, e1_q, e1_d;
	logic v0_q, v0_d, v1_q, v1_d;
	logic [DATA_W-1:0] rd_data;
	logic selected, push, stall, adv, wr_now, rd_now;
	logic [BURST_W-1:0] cnt_next, low_bits;
	logic [DATA_W-1:0] merged;
	logic [LANES-1:0] wr_lanes;

	// overlay the strobed lanes of a newer word onto an older one
	function automatic logic [DATA_W-1:0] merge_lanes(
		input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word,
		input logic [LANES-1:0] lanes
	);
		logic [DATA_W-1:0] res;
		res = old_word;
		for (int i = 0; i < LANES; i++) begin
			if (lanes[i]) begin
				res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction : merge_lanes

	////////////////////////////////////////////////////////////////////////
	// edge qualification and array control
	always_comb begin
		selected = !chip_select_a_n && !chip_select_c_n && chip_select_b;
		push = (s2_q.op == OP_READ);
		stall = push && v1_q && !beat_ready; // a full buffer holds the pipeline
		adv = !rst && !clock_enable_n && !stall; // no array access during reset
		wr_lanes = ~byte_write_strobes_n;
		wr_now = adv && (s3_q.op == OP_WRITE);
		rd_now = adv && (s1_q.op == OP_READ);
	end

	pbsp_array u_array (
		.clk(clk),
		.wr_en(wr_now),
		.wr_addr(s3_q.addr),
		.wr_lanes(wr_lanes),
		.wr_data(dq_in),
		.rd_en(rd_now),
		.rd_addr(s1_q.addr),
		.rd_data_q(rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// load, burst counter and pipeline stages
	always_comb begin
		s1_d = s1_q;
		s2_d = s2_q;
		s3_d = s3_q;
		burst_op_d = burst_op_q;
		base_d = base_q;
		cnt_d = cnt_q;
		cnt_next = cnt_q + BURST_STEP; // wraps modulo four
		if (burst_order_select) begin
			low_bits = base_q[BURST_W-1:0] ^ cnt_next;
		end else begin
			low_bits = base_q[BURST_W-1:0] + cnt_next;
		end
		if (adv) begin
			s2_d = s1_q;
			s3_d = s2_q; // two edges from sample to data cycle
			if (!advance_or_load) begin
				// load: a new operation or a stop
				if (selected) begin
					burst_op_d = read_write ? OP_READ : OP_WRITE;
				end else begin
					burst_op_d = OP_IDLE;
				end
				base_d = address;
				cnt_d = BURST_ZERO;
				s1_d.op = burst_op_d;
				s1_d.addr = address;
			end else begin
				// advance: direction kept from the load
				cnt_d = cnt_next;
				s1_d.op = burst_op_q;
				s1_d.addr = {base_q[ADDR_W-1:BURST_W], low_bits};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= STAGE_IDLE;
			s2_q <= STAGE_IDLE;
			s3_q <= STAGE_IDLE;
			burst_op_q <= OP_IDLE;
			base_q <= ADDR_ZERO;
			cnt_q <= BURST_ZERO;
		end else begin
			s1_q <= s1_d; // sampled only on the rising edge
			s2_q <= s2_d;
			s3_q <= s3_d;
			burst_op_q <= burst_op_d;
			base_q <= base_d;
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data with forwarding from writes the array read missed
	always_comb begin
		wrec_d = wrec_q;
		dq_out_d = dq_out_q;
		dq_oe_d = dq_oe_q;
		merged = rd_data;
		if (wrec_q.valid && wrec_q.addr == s2_q.addr) begin
			merged = merge_lanes(merged, wrec_q.data, wrec_q.lanes);
		end
		if (wr_now && s3_q.addr == s2_q.addr) begin
			merged = merge_lanes(merged, dq_in, wr_lanes);
		end
		if (adv) begin
			wrec_d.valid = wr_now;
			wrec_d.addr = s3_q.addr;
			wrec_d.lanes = wr_lanes;
			wrec_d.data = dq_in;
			if (push) begin
				dq_out_d = merged;
			end
			dq_oe_d = push && !output_enable_n; // floats after a stop
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrec_q <= WREC_NONE;
			dq_out_q <= DATA_ZERO;
			dq_oe_q <= 1'b0;
		end else begin
			wrec_q <= wrec_d;
			dq_out_q <= dq_out_d; // launched from the edge
			dq_oe_q <= dq_oe_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two-entry buffer copying each read beat to the user side
	always_comb begin
		e0_d = e0_q;
		e1_d = e1_q;
		v0_d = v0_q;
		v1_d = v1_q;
		if (v0_q && beat_ready) begin
			e0_d = e1_q;
			v0_d = v1_q;
			v1_d = 1'b0;
		end
		if (adv && push) begin
			if (!v0_d) begin
				e0_d = merged;
				v0_d = 1'b1;
			end else begin
				e1_d = merged;
				v1_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			e0_q <= DATA_ZERO;
			e1_q <= DATA_ZERO;
			v0_q <= 1'b0;
			v1_q <= 1'b0;
		end else begin
			e0_q <= e0_d;
			e1_q <= e1_d;
			v0_q <= v0_d;
			v1_q <= v1_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	always_comb begin
		dq_out = dq_out_q;
		dq_oe = dq_oe_q;
		beat_valid = v0_q;
		beat_data = e0_q;
	end
endmodule : pbsp_port

//--- testbench/pbsp_ctrl_model.sv
// controller-side data, strobe and output enable driver
`timescale 1ns/1ns
module pbsp_ctrl_model
	import pbsp_pkg::*;
(
	input wire logic clk,
	input wire logic [31:0] rnd,
	output logic [pbsp_pkg::DATA_W-1:0] dq_in,
	output logic [pbsp_pkg::LANES-1:0] byte_write_strobes_n,
	output logic output_enable_n
);
	// new word every cycle so a late sample never sees stale data
	always @(negedge clk) begin
		dq_in <= {rnd[3:0], rnd};
		byte_write_strobes_n <= rnd[7:4];
		output_enable_n <= rnd[10:8] == 3'h0;
	end
endmodule : pbsp_ctrl_model

//--- testbench/pbsp_port_asserts.sv
// pin-level assertions for the burst memory port
`timescale 1ns/1ns
module pbsp_port_asserts
	import pbsp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic read_write,
	input wire logic advance_or_load,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b,
	input wire logic chip_select_c_n,
	input wire logic clock_enable_n,
	input wire logic output_enable_n,
	input wire logic beat_ready,
	input wire logic [pbsp_pkg::DATA_W-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic beat_valid,
	input wire logic [pbsp_pkg::DATA_W-1:0] beat_data
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// enabled, unstalled edges and the kinds of load
	wire logic sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
	wire logic go = !clock_enable_n && beat_ready;
	wire logic ld = go && !advance_or_load;
	wire logic gol = go && !output_enable_n;
	sequence rd_ld;
		ld && sel && read_write;
	endsequence
	sequence stop_ld;
		ld && !sel;
	endsequence
	sequence adv_rd;
		gol && advance_or_load;
	endsequence
	a_read_two_cycles: assert property (rd_ld ##1 go ##1 gol |=> dq_oe)
		else $error("read beat not driven");
	a_burst_beats: assert property (rd_ld ##1 adv_rd ##1 adv_rd ##1 adv_rd |=> dq_oe)
		else $error("burst beat not driven");
	a_stop_floats: assert property (stop_ld ##1 go ##1 go |=> !dq_oe)
		else $error("bus driven after deselect");
	a_write_floats: assert property (ld && sel && !read_write ##1 go ##1 go |=> !dq_oe)
		else $error("bus driven for a write");
	a_adv_after_stop: assert property (stop_ld ##1 (go && advance_or_load) ##1 go ##1 go |=> !dq_oe)
		else $error("bus driven on idle advance");
	a_oe_gates_bus: assert property ($rose(dq_oe) |-> !$past(output_enable_n))
		else $error("bus driven with output enable high");
	a_block_holds: assert property (clock_enable_n |=> $stable(dq_oe) && $stable(dq_out))
		else $error("outputs moved on a blocked edge");
	a_beat_holds: assert property (beat_valid && !beat_ready |=> beat_valid && $stable(beat_data))
		else $error("beat dropped while stalled");
endmodule : pbsp_port_asserts
bind pbsp_port pbsp_port_asserts u_pbsp_port_asserts (
	.clk(clk),
	.rst(rst),
	.read_write(read_write),
	.advance_or_load(advance_or_load),
	.chip_select_a_n(chip_select_a_n),
	.chip_select_b(chip_select_b),
	.chip_select_c_n(chip_select_c_n),
	.clock_enable_n(clock_enable_n),
	.output_enable_n(output_enable_n),
	.beat_ready(beat_ready),
	.dq_out(dq_out),
	.dq_oe(dq_oe),
	.beat_valid(beat_valid),
	.beat_data(beat_data)
);

//--- testbench/pbsp_port_tb_top.sv
// self-checking bench for the burst memory port with a reference model
`timescale 1ns/1ns
module pbsp_port_tb_top;
	import pbsp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] address = ADDR_ZERO;
	logic read_write = 1'b0, advance_or_load = 1'b0, chip_select_a_n = 1'b1, chip_select_b = 1'b0;
	logic chip_select_c_n = 1'b1, clock_enable_n = 1'b0, burst_order_select = 1'b0, beat_ready = 1'b0;
	logic dq_oe, beat_valid, output_enable_n, exp_oe, s;
	logic [LANES-1:0] byte_write_strobes_n;
	logic [DATA_W-1:0] dq_in, dq_out, beat_data, exp_dq;
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] bq [$];
	logic [31:0] r, rnd = 32'h0;
	integer seed = 20859, bad_count = 0, comparisons = 0, cyc = 0, op1, op2, op3, cur, k, a1, a2, a3, st, i, n;
	pbsp_port u_pbsp_port (
		.clk(clk),
		.rst(rst),
		.address(address),
		.read_write(read_write),
		.advance_or_load(advance_or_load),
		.chip_select_a_n(chip_select_a_n),
		.chip_select_b(chip_select_b),
		.chip_select_c_n(chip_select_c_n),
		.clock_enable_n(clock_enable_n),
		.byte_write_strobes_n(byte_write_strobes_n),
		.output_enable_n(output_enable_n),
		.burst_order_select(burst_order_select),
		.dq_in(dq_in),
		.dq_out(dq_out),
		.dq_oe(dq_oe),
		.beat_valid(beat_valid),
		.beat_data(beat_data),
		.beat_ready(beat_ready)
	);
	pbsp_ctrl_model u_pbsp_ctrl_model (
		.clk(clk),
		.rnd(rnd),
		.dq_in(dq_in),
		.byte_write_strobes_n(byte_write_strobes_n),
		.output_enable_n(output_enable_n)
	);
	always #10 clk = ~clk;
	task automatic check(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic summarize;
		if (bad_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	// reference pipeline: buffer drains, write retires, read launches, new cycle enters
	always @(posedge clk) begin
		if (rst) begin
			op1 = 0; op2 = 0; op3 = 0; cur = 0; exp_oe = 1'b0;
			bq.delete();
		end else begin
			if (beat_ready && bq.size() > 0) begin
				bq.delete(0);
			end
			if (!clock_enable_n && !(op2 == 1 && bq.size() == 2 && !beat_ready)) begin
				for (i = 0; i < LANES; i++) begin
					if (op3 == 2 && !byte_write_strobes_n[i]) mem[a3][i*LANE_W +: LANE_W] = dq_in[i*LANE_W +: LANE_W];
				end
				exp_oe = op2 == 1 && !output_enable_n;
				if (op2 == 1) begin
					exp_dq = mem.exists(a2) ? mem[a2] : 'x;
					bq.push_back(exp_dq);
				end
				op3 = op2; a3 = a2;
				op2 = op1; a2 = a1;
				if (!advance_or_load) begin
					cur = (!chip_select_a_n && chip_select_b && !chip_select_c_n) ? (read_write ? 1 : 2) : 0;
					st = address; k = 0;
				end else k = (k + 1) % 4;
				op1 = cur;
				a1 = burst_order_select ? st ^ k : (st & ~3) | ((st + k) & 3);
			end
		end
	end
	// pin checks once outputs settle, plus the hang limit
	always @(negedge clk) begin
		cyc++;
		if (!rst) begin
			check("dq_oe", exp_oe, dq_oe);
			if (exp_oe) check("dq_out", exp_dq, dq_out);
			check("beat_valid", bq.size() > 0, beat_valid);
			if (bq.size() > 0) check("beat_data", bq[0], beat_data);
		end
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end
	// random mix of loads, bursts, deselects, blocked edges and stalls, with a second reset
	initial begin
		repeat (12) @(negedge clk);
		for (n = 0; n < 3000; n++) begin
			r = $random(seed);
			rnd <= $random(seed);
			rst = n >= 1500 && n < 1502;
			advance_or_load = r[1:0] != 2'h0;
			if (!advance_or_load) burst_order_select = r[2];
			address = {r[17:16], 12'h0, r[6:3]};
			read_write = r[7];
			clock_enable_n = r[10:8] == 3'h0;
			beat_ready = !clock_enable_n && r[12:11] != 2'h0;
			s = r[14:13] != 2'h0;
			chip_select_a_n = !s && r[15];
			chip_select_c_n = !s && r[18];
			chip_select_b = s || (r[15] || r[18]) && r[19];
			@(negedge clk);
		end
		summarize();
	end
endmodule : pbsp_port_tb_top
